/* File: bench/spdfp_checker.sv */
`timescale 1ns/1ps
module spdfp_checker (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic REL_CLK_A_I,
    input wire logic REL_CLK_B_I,
    input wire spdfp_pkg::spdfp_req_s REG_REQ_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic OUT_C_O,
    input wire logic OUT_D_O
);
    import spdfp_pkg::*;
    logic [7:0] m [6];
    logic [3:0] cst, dst;
    logic [6:0] ha;
    logic [23:0] c, d;
    logic [7:0] rexp, off;
    logic fa, rw, fw;
    assign off = REG_REQ_I.addr - SPDFP_DIV_C_ADDR;
    assign c = {m[0], m[1], m[2]};
    assign d = {m[3], m[4], m[5]};
    assign rexp = (off < 8'h6) ? m[off[2:0]] : 8'h00;
    // Judge frame behaviour only once the config has settled for 15 cycles
    assign fa = c[23:20] == SPDFP_MODE_FRAME && c[17:16] == SPDFP_SEL_A && cst == 4'hf;
    assign rw = |(ha[5:1] & ~ha[6:2]);
    assign fw = |(~ha[5:1] & ha[6:2]);
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            m <= '{default: 8'h00};
            cst <= 4'h0;
            dst <= 4'h0;
            ha <= 7'h00;
        end else begin
            ha <= {ha[5:0], REL_CLK_A_I};
            cst <= (REG_REQ_I.wr && off < 8'h3) ? 4'h0 : cst + {3'h0, cst != 4'hf};
            dst <= (REG_REQ_I.wr && off > 8'h2 && off < 8'h6) ? 4'h0 : dst + {3'h0, dst != 4'hf};
            if (REG_REQ_I.wr && off < 8'h6) m[off[2:0]] <= REG_REQ_I.wdata;
        end
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    rd_data_a: assert property (REG_REQ_I.rd && !REG_REQ_I.wr |=> REG_RDATA_O == $past(rexp))
        else $error("read byte wrong");
    idle_c_a: assert property (c < 24'h2 && cst == 4'hf |-> !OUT_C_O) else $error("C not idle");
    idle_d_a: assert property (d < 24'h2 && dst == 4'hf |-> !OUT_D_O) else $error("D not idle");
    div_two_a: assert property (c == 24'h2 && cst == 4'hf |-> OUT_C_O != $past(OUT_C_O))
        else $error("ratio two not toggling");
    rsv_c_a: assert property (c[23:16] == 8'hfa && cst == 4'hf |-> $stable(OUT_C_O)) else $error("C moved");
    rsv_d_a: assert property (d[23:20] == 4'hf && d[17:16] == SPDFP_SEL_D && dst == 4'hf |-> $stable(OUT_D_O))
        else $error("D moved");
    pulse_phase_a: assert property (fa && $rose(OUT_C_O ^ c[18]) |-> (c[19] ? rw : fw))
        else $error("pulse start off edge");
    rel_quiet_a: assert property ((fa && $stable(REL_CLK_A_I)) [*8] |-> $stable(OUT_C_O))
        else $error("pulse moved without related edge");
    cover property (fa && $rose(OUT_C_O));
    cover property (c == 24'h2 && cst == 4'hf);
    cover property (REG_REQ_I.rd && off > 8'h5);
endmodule
bind spdfp_top spdfp_checker u_chk (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .REL_CLK_A_I(REL_CLK_A_I),
    .REL_CLK_B_I(REL_CLK_B_I), .REG_REQ_I(REG_REQ_I), .REG_RDATA_O(REG_RDATA_O), .OUT_C_O(OUT_C_O),
    .OUT_D_O(OUT_D_O));

/* File: bench/spdfp_relclk_model.sv */
`timescale 1ns/1ps
module spdfp_relclk_model #(parameter int HALF_A = 10, parameter int HALF_B = 8) (
    input wire logic clk_i,
    output logic rel_a_o,
    output logic rel_b_o
);
    int ca = 0;
    int cb = 0;
    logic ra = 1'b0;
    logic rb = 1'b0;
    assign rel_a_o = ra;
    assign rel_b_o = rb;
    // Sibling dividers run free and locked to the VCO, so widths come out exact
    always @(posedge clk_i) begin
        ca <= (ca == HALF_A - 1) ? 0 : ca + 1;
        cb <= (cb == HALF_B - 1) ? 0 : cb + 1;
        if (ca == HALF_A - 1) ra <= ~ra;
        if (cb == HALF_B - 1) rb <= ~rb;
    end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
    import spdfp_pkg::*;
    logic CLOCK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic rel_a, rel_b, out_c, out_d;
    logic [7:0] rdata;
    logic rd_pend = 1'b0;
    spdfp_req_s req = '0;
    logic [7:0] q [$];
    int bad_count = 0;
    int n_tests = 0;
    always #5 CLOCK_I = ~CLOCK_I;
    spdfp_relclk_model #(.HALF_A(10), .HALF_B(8)) u_rel (.clk_i(CLOCK_I), .rel_a_o(rel_a), .rel_b_o(rel_b));
    spdfp_top u_dut (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .REL_CLK_A_I(rel_a), .REL_CLK_B_I(rel_b),
        .REG_REQ_I(req), .REG_RDATA_O(rdata), .OUT_C_O(out_c), .OUT_D_O(out_d));
    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [7:0] dat);
        @(negedge CLOCK_I);
        req <= '{wr: w, rd: !w, addr: a, wdata: dat};
        @(negedge CLOCK_I);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
    endtask
    task rdb(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask
    task wcfg(input logic [7:0] b, input logic [23:0] v);
        for (int k = 0; k < 3; k++) acc(1'b1, b + 8'(k), v[23 - 8 * k -: 8]);
    endtask
    task rcfg(input logic [7:0] b, input logic [23:0] v);
        for (int k = 0; k < 3; k++) rdb(b + 8'(k), v[23 - 8 * k -: 8]);
    endtask
    // Active width and start-to-start spacing of the next whole pulse
    task meas(input logic d, input logic act, input logic useb, output int w, output int p, output logic rl);
        int n;
        w = 0;
        p = 0;
        n = 0;
        repeat (130) @(negedge CLOCK_I);
        while ((d ? out_d : out_c) === act && n < 3000) begin @(negedge CLOCK_I); n++; end
        while ((d ? out_d : out_c) !== act && n < 3000) begin @(negedge CLOCK_I); n++; end
        rl = useb ? rel_b : rel_a;
        while ((d ? out_d : out_c) === act && n < 3000) begin @(negedge CLOCK_I); w++; p++; n++; end
        while ((d ? out_d : out_c) !== act && n < 3000) begin @(negedge CLOCK_I); p++; n++; end
    endtask
    always @(posedge CLOCK_I) rd_pend <= req.rd;
    always @(negedge CLOCK_I) if (rd_pend === 1'b1) chk(rdata, q.pop_front());
    initial begin
        #300000;
        bad_count++;
        summarize;
    end
    initial begin
        int w, p, i;
        int nv [3];
        logic rl;
        logic [23:0] v;
        nv = '{2, 6, 7};
        void'($urandom(32'he822));
        repeat (5) @(negedge CLOCK_I);
        RST_N_I = 1'b1;
        rcfg(SPDFP_DIV_C_ADDR, SPDFP_DIV_RESET);
        rcfg(SPDFP_DIV_D_ADDR, SPDFP_DIV_RESET);
        acc(1'b1, 8'hb0, 8'h5a);
        rdb(8'hb0, 8'h00);
        for (i = 0; i < 4; i++) begin
            v = 24'($urandom % 32'h00f00000);
            wcfg(i[0] ? SPDFP_DIV_D_ADDR : SPDFP_DIV_C_ADDR, v);
            rcfg(i[0] ? SPDFP_DIV_D_ADDR : SPDFP_DIV_C_ADDR, v);
        end
        foreach (nv[k]) begin
            wcfg(SPDFP_DIV_C_ADDR, 24'(nv[k]));
            meas(1'b0, 1'b1, 1'b0, w, p, rl);
            chk(w, (nv[k] + 1) / 2);
            chk(p, nv[k]);
        end
        for (i = 0; i < 8; i++) begin
            wcfg(SPDFP_DIV_C_ADDR, {4'hf, i[2], i[1], 1'b0, i[0], 16'h0003});
            meas(1'b0, !i[1], i[0], w, p, rl);
            chk(w, i[0] ? 16 : 20);
            chk(p, i[0] ? 48 : 60);
            chk(rl, i[2]);
        end
        // Each output is first paced by the other, then both are programmed to select themselves
        wcfg(SPDFP_DIV_C_ADDR, 24'h000004);
        wcfg(SPDFP_DIV_D_ADDR, 24'hfa0005);
        meas(1'b1, 1'b1, 1'b0, w, p, rl);
        chk(w, 4);
        chk(p, 20);
        wcfg(SPDFP_DIV_D_ADDR, 24'h000008);
        wcfg(SPDFP_DIV_C_ADDR, 24'hfb0002);
        meas(1'b0, 1'b1, 1'b0, w, p, rl);
        chk(w, 8);
        chk(p, 16);
        wcfg(SPDFP_DIV_C_ADDR, 24'hfa0003);
        wcfg(SPDFP_DIV_D_ADDR, 24'hfb0003);
        repeat (40) @(negedge CLOCK_I);
        // A reset in mid-run must clear both dividers and pull both outputs low
        RST_N_I = 1'b0;
        repeat (2) @(negedge CLOCK_I);
        chk({out_c, out_d}, 2'h0);
        RST_N_I = 1'b1;
        rcfg(SPDFP_DIV_C_ADDR, SPDFP_DIV_RESET);
        rcfg(SPDFP_DIV_D_ADDR, SPDFP_DIV_RESET);
        repeat (20) @(negedge CLOCK_I);
        chk({out_c, out_d}, 2'h0);
        summarize;
    end
endmodule

/* File: hdl/spdfp_pkg.sv */
package spdfp_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    // Each divider register spans three bytes, the lowest address holds bits 23:16
    localparam logic [7:0] SPDFP_DIV_C_ADDR = 8'haa;
    localparam logic [7:0] SPDFP_DIV_D_ADDR = 8'had;
    localparam int SPDFP_REG_BYTES = 3;
    localparam logic [23:0] SPDFP_DIV_RESET = 24'h000000;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int SPDFP_MODE_MSB = 23;
    localparam int SPDFP_MODE_LSB = 20;
    localparam logic [3:0] SPDFP_MODE_FRAME = 4'hf;
    localparam int SPDFP_TYPE_BIT = 19;
    localparam int SPDFP_POL_BIT = 18;
    localparam int SPDFP_SEL_MSB = 17;
    localparam int SPDFP_SEL_LSB = 16;
    localparam int SPDFP_PER_MSB = 15;
    localparam int SPDFP_PER_LSB = 0;
    localparam logic [23:0] SPDFP_DIV_MAX = 24'hefffff;

    // ****************************************
    // Related clock selector codes
    // ****************************************
    localparam logic [1:0] SPDFP_SEL_A = 2'h0;
    localparam logic [1:0] SPDFP_SEL_B = 2'h1;
    localparam logic [1:0] SPDFP_SEL_C = 2'h2;
    localparam logic [1:0] SPDFP_SEL_D = 2'h3;
    localparam int SPDFP_CH_C = 0;
    localparam int SPDFP_CH_D = 1;
    localparam int SPDFP_NUM_CH = 2;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spdfp_req_s;

    typedef struct packed {
        logic [23:0] cfg;
        logic rel_prev;
        logic [23:0] div_cnt;
        logic [15:0] frm_cnt;
        logic frm_act;
        logic out;
    } spdfp_chan_s;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        spdfp_chan_s [SPDFP_NUM_CH-1:0] ch;
        logic [7:0] rdata;
    } spdfp_state_s;

endpackage

/* File: hdl/spdfp_top.sv */
`timescale 1ns/1ps
module spdfp_top (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic REL_CLK_A_I,
    input wire logic REL_CLK_B_I,
    input wire spdfp_pkg::spdfp_req_s REG_REQ_I,
    output logic [7:0] REG_RDATA_O,
    output logic OUT_C_O,
    output logic OUT_D_O
);
    import spdfp_pkg::*;

    spdfp_state_s st_reg;
    spdfp_state_s st_next;

    // ****************************************
    // Elaboration checks
    // ****************************************
    // The byte decoder and the field slices assume this exact layout, so a package
    // edit that moves a field other than the spacing field stops the build instead of aliasing bits.
    if (SPDFP_MODE_MSB + 1 != SPDFP_REG_BYTES * 8) begin : g_chk_word
        $error("Divider word and register bytes disagree");
    end

    if (SPDFP_DIV_D_ADDR != SPDFP_DIV_C_ADDR + 8'(SPDFP_REG_BYTES)) begin : g_chk_map
        $error("Divider D must follow divider C directly");
    end

    if (SPDFP_MODE_MSB - SPDFP_MODE_LSB != 3) begin : g_chk_mode
        $error("Mode code must be one nibble");
    end

    if (SPDFP_TYPE_BIT != SPDFP_MODE_LSB - 1 || SPDFP_POL_BIT != SPDFP_TYPE_BIT - 1) begin : g_chk_flags
        $error("Type and polarity bits out of place");
    end

    if (SPDFP_SEL_MSB != SPDFP_POL_BIT - 1 || SPDFP_SEL_LSB != SPDFP_SEL_MSB - 1) begin : g_chk_sel
        $error("Related clock selector must be two bits below polarity");
    end

    if (SPDFP_PER_MSB - SPDFP_PER_LSB != 15) begin : g_chk_per
        $error("Spacing field must match the sixteen bit frame counter");
    end

    if (SPDFP_DIV_MAX[SPDFP_MODE_MSB:SPDFP_MODE_LSB] == SPDFP_MODE_FRAME) begin : g_chk_max
        $error("Largest divide ratio collides with the frame code");
    end

    if (SPDFP_DIV_RESET[SPDFP_MODE_MSB:SPDFP_MODE_LSB] == SPDFP_MODE_FRAME) begin : g_chk_reset
        $error("Reset value must leave both outputs in divide mode");
    end

    if (SPDFP_NUM_CH != 2 || SPDFP_CH_C == SPDFP_CH_D) begin : g_chk_ch
        $error("Exactly two outputs, C and D, are served");
    end

    // ****************************************
    // Related clock selection
    // ****************************************
    // Returns the level of the related clock in bit 1 and a valid flag in bit 0.
    // A reserved code yields no clock, so the pulse generator simply idles.
    // Self-selection is blocked here; an output that picks itself gets no clock.
    function automatic logic [1:0] rel_pick(input int ch, input logic [1:0] sel,
                                            input logic a, input logic b,
                                            input logic c, input logic d);
        logic [1:0] r;
        r = 2'h0;
        case (sel)
            SPDFP_SEL_A: r = {a, 1'b1};
            SPDFP_SEL_B: r = {b, 1'b1};
            SPDFP_SEL_C: r = (ch == SPDFP_CH_D) ? {c, 1'b1} : 2'h0;
            SPDFP_SEL_D: r = (ch == SPDFP_CH_C) ? {d, 1'b1} : 2'h0;
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [1:0] pick;
        logic rel;
        logic rise;
        logic fall;
        logic [23:0] cfg;
        logic [23:0] ratio;
        logic [23:0] half;
        logic [15:0] per_m1;
        logic [7:0] byte_sel;
        pick = 2'h0;
        rel = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        cfg = 24'h000000;
        ratio = 24'h000000;
        half = 24'h000000;
        per_m1 = 16'h0000;
        byte_sel = 8'h00;
        st_next = st_reg;

        // Pin clocks pass two flops before anything looks at them
        // Pulses therefore trail the A and B pins by three cycles, C and D by one
        st_next.sync1 = {REL_CLK_B_I, REL_CLK_A_I};
        st_next.sync2 = st_reg.sync1;

        for (int k = 0; k < SPDFP_NUM_CH; k++) begin
            cfg = st_reg.ch[k].cfg;
            pick = rel_pick(k, cfg[SPDFP_SEL_MSB:SPDFP_SEL_LSB], st_reg.sync2[0], st_reg.sync2[1],
                            st_reg.ch[SPDFP_CH_C].out, st_reg.ch[SPDFP_CH_D].out);
            rel = pick[1] & pick[0];
            rise = rel & ~st_reg.ch[k].rel_prev;
            fall = ~rel & st_reg.ch[k].rel_prev & pick[0];
            st_next.ch[k].rel_prev = rel;

            if (cfg[SPDFP_MODE_MSB:SPDFP_MODE_LSB] == SPDFP_MODE_FRAME) begin
                st_next.ch[k].div_cnt = 24'h000000;
                // frame spacing, zero treated as one
                per_m1 = (cfg[SPDFP_PER_MSB:SPDFP_PER_LSB] == 16'h0000) ? 16'h0000
                         : cfg[SPDFP_PER_MSB:SPDFP_PER_LSB] - 16'h0001;
                // A new spacing acts at once; a count already past the end wraps to zero
                // count on related rising edges
                if (rise) begin
                    st_next.ch[k].frm_cnt = (st_reg.ch[k].frm_cnt >= per_m1) ? 16'h0000
                                            : st_reg.ch[k].frm_cnt + 16'h0001;
                end
                // edge type: boundary rising edge opens the pulse
                if (cfg[SPDFP_TYPE_BIT]) begin
                    if (rise) begin
                        st_next.ch[k].frm_act = (st_next.ch[k].frm_cnt == 16'h0000);
                    end
                end else begin
                    // centred type: falling edges half a period either side
                    if (fall) begin
                        st_next.ch[k].frm_act = (st_reg.ch[k].frm_cnt == per_m1);
                    end
                end
                st_next.ch[k].out = st_next.ch[k].frm_act ^ cfg[SPDFP_POL_BIT];
            end else begin
                // divide mode; odd ratios run one VCO cycle longer high
                st_next.ch[k].frm_cnt = 16'h0000;
                st_next.ch[k].frm_act = 1'b0;
                ratio = cfg;
                half = (ratio >> 1) + {23'h000000, ratio[0]};
                if (ratio < 24'h000002) begin
                    // A register output cannot follow the VCO itself, so these idle low
                    st_next.ch[k].div_cnt = 24'h000000;
                    st_next.ch[k].out = 1'b0;
                end else begin
                    // A shorter ratio applies at once; the counter restarts if already past it
                    st_next.ch[k].div_cnt = (st_reg.ch[k].div_cnt >= ratio - 24'h000001) ? 24'h000000
                                            : st_reg.ch[k].div_cnt + 24'h000001;
                    st_next.ch[k].out = (st_next.ch[k].div_cnt < half);
                end
            end
        end

        // ****************************************
        // Register port
        // ****************************************
        // Byte writes land directly; a new setting takes effect on the next cycle
        // A read and a write of one byte in the same cycle return the old byte
        for (int k = 0; k < SPDFP_NUM_CH; k++) begin
            for (int b = 0; b < SPDFP_REG_BYTES; b++) begin
                byte_sel = ((k == SPDFP_CH_C) ? SPDFP_DIV_C_ADDR : SPDFP_DIV_D_ADDR) + 8'(b);
                if (REG_REQ_I.wr && REG_REQ_I.addr == byte_sel) begin
                    st_next.ch[k].cfg[(SPDFP_REG_BYTES - 1 - b) * 8 +: 8] = REG_REQ_I.wdata;
                end
                if (REG_REQ_I.rd && REG_REQ_I.addr == byte_sel) begin
                    st_next.rdata = st_reg.ch[k].cfg[(SPDFP_REG_BYTES - 1 - b) * 8 +: 8];
                end
            end
        end
        if (REG_REQ_I.rd && !(REG_REQ_I.addr >= SPDFP_DIV_C_ADDR &&
                              REG_REQ_I.addr < SPDFP_DIV_D_ADDR + 8'(SPDFP_REG_BYTES))) begin
            st_next.rdata = 8'h00;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_reg.sync1 <= 2'h0;
            st_reg.sync2 <= 2'h0;
            st_reg.rdata <= 8'h00;
            for (int k = 0; k < SPDFP_NUM_CH; k++) begin
                st_reg.ch[k].cfg <= SPDFP_DIV_RESET;
                st_reg.ch[k].rel_prev <= 1'b0;
                st_reg.ch[k].div_cnt <= 24'h000000;
                st_reg.ch[k].frm_cnt <= 16'h0000;
                st_reg.ch[k].frm_act <= 1'b0;
                st_reg.ch[k].out <= 1'b0;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    // Pins come straight from state flops, so no decode glitch reaches them
    assign REG_RDATA_O = st_reg.rdata;
    assign OUT_C_O = st_reg.ch[SPDFP_CH_C].out;
    assign OUT_D_O = st_reg.ch[SPDFP_CH_D].out;

endmodule
